// ===== inc/srp_cfg.svh
// Constants for the sleep regulator power-mode block.
// Assumes inclusion by the package and the design; definitions only.
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH
`define SRP_ADDR_CTRL     12'h000
`define SRP_ADDR_STATUS   12'h004
`define SRP_BIT_RSVD      0
`define SRP_BIT_PM        1
`define SRP_CTRL_RESET    8'h01
`define SRP_CTRL_WMASK    8'h02
`define SRP_CTRL_FORCE    8'h01
`define SRP_STAB_NS       2000
`define SRP_CLK_MHZ       25
`endif

// ===== inc/srp_pkg.sv
// Types for the sleep regulator power-mode block.
// Assumes srp_cfg.svh is on the include path.
`include "srp_cfg.svh"
package srp_pkg;
   typedef enum logic [1:0] {
      SRP_AWAKE  = 2'b00,
      SRP_SLEEP  = 2'b01,
      SRP_STABLE = 2'b10
   } srp_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } srp_apb_req_t;

   typedef struct packed {
      logic        ldo_lowpower;
      logic        ref_lowpower;
      logic        wake_hold;
   } srp_reg_ctl_t;
endpackage : srp_pkg

// ===== design/srp_sleep_regulator.sv
// Sleep regulator power-mode controller with APB register access.
// Assumes sleep_req/wake_evt come from the core's power manager, one clock.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "srp_cfg.svh"

module srp_sleep_regulator #(
   parameter bit          REGULATED  = 1'b1,
   parameter int unsigned STAB_CYCLES =
      ((`SRP_STAB_NS * `SRP_CLK_MHZ) + 999) / 1000
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire srp_pkg::srp_apb_req_t apb_req,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 sleep_req,
   input  wire logic                 wake_evt,
   output srp_pkg::srp_reg_ctl_t     reg_ctl,
   output logic                      run_ok
);
   import srp_pkg::*;

   localparam int unsigned CW = $clog2(STAB_CYCLES + 1);
   localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);

   logic [7:0]    ctrl;
   srp_state_t    state;
   logic [CW-1:0] stab_cnt;
   logic          access;
   logic          hit_ctrl;
   logic          hit_stat;
   logic          pm_eff;

   assign access   = apb_req.psel && apb_req.penable;
   assign hit_ctrl = apb_req.paddr == `SRP_ADDR_CTRL;
   assign hit_stat = apb_req.paddr == `SRP_ADDR_STATUS;
   // Unregulated parts never see a selectable mode
   assign pm_eff   = REGULATED && ctrl[`SRP_BIT_PM];

   // Control register: only the mode bit is writable, bit 0 pinned high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `SRP_CTRL_RESET;
      end else if (access && apb_req.pwrite && hit_ctrl && REGULATED) begin
         ctrl <= (apb_req.pwdata[7:0] & `SRP_CTRL_WMASK) | `SRP_CTRL_FORCE;
      end
   end

   // Zero-wait APB answer, registered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_req.psel && !apb_req.penable;
         pslverr <= apb_req.psel && !apb_req.penable && !hit_ctrl && !hit_stat;
         if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl) begin
            prdata <= {24'h00_0000, ctrl};
         end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_stat) begin
            prdata <= {29'h0000_0000, pm_eff, state};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Sleep sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= SRP_AWAKE;
         stab_cnt <= '0;
      end else begin
         case (state)
            SRP_AWAKE: begin
               if (sleep_req) begin
                  state <= SRP_SLEEP;
               end
            end
            SRP_SLEEP: begin
               if (wake_evt) begin
                  if (pm_eff) begin
                     state    <= SRP_STABLE;
                     stab_cnt <= '0;
                  end else begin
                     state <= SRP_AWAKE;
                  end
               end
            end
            SRP_STABLE: begin
               if (stab_cnt == STAB_LAST) begin
                  state <= SRP_AWAKE;
               end else begin
                  stab_cnt <= stab_cnt + CW'(1);
               end
            end
            default: state <= SRP_AWAKE;
         endcase
      end
   end

   // Regulator controls follow the next state, the low-power bits only from the second sleep cycle, so they are registered outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_ctl <= '0;
         run_ok  <= 1'b1;
      end else begin
         reg_ctl.ldo_lowpower <= (state == SRP_SLEEP) && !wake_evt && pm_eff;
         reg_ctl.ref_lowpower <= (state == SRP_SLEEP) && !wake_evt && pm_eff;
         reg_ctl.wake_hold    <= (state == SRP_SLEEP && wake_evt && pm_eff) ||
                                 (state == SRP_STABLE && stab_cnt != STAB_LAST);
         run_ok <= (state == SRP_AWAKE && !sleep_req) ||
                   (state == SRP_SLEEP && wake_evt && !pm_eff) ||
                   (state == SRP_STABLE && stab_cnt == STAB_LAST);
      end
   end

   property p_rsvd_one;
      @(posedge core_clk) disable iff (!rst_n)
      ctrl[`SRP_BIT_RSVD] && (ctrl[7:2] == 6'h00);
   endproperty
   a_rsvd_one: assert property (p_rsvd_one) else $error("reserved bits wrong");

   property p_upper_ignored;
      @(posedge core_clk) disable iff (!rst_n)
      (access && apb_req.pwrite && hit_ctrl) |=> ctrl[7:2] == 6'h00;
   endproperty
   a_upper_ignored: assert property (p_upper_ignored) else $error("upper bits written");

   property p_lp_only_sleep;
      @(posedge core_clk) disable iff (!rst_n)
      reg_ctl.ldo_lowpower |-> $past(state) == SRP_SLEEP && $past(pm_eff);
   endproperty
   a_lp_only_sleep: assert property (p_lp_only_sleep) else $error("low power while awake");

   property p_normal_fast;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_SLEEP && wake_evt && !pm_eff) |=> run_ok && state == SRP_AWAKE;
   endproperty
   a_normal_fast: assert property (p_normal_fast) else $error("normal wake delayed");

   property p_lp_delay;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_SLEEP && wake_evt && pm_eff) |=> !run_ok && state == SRP_STABLE;
   endproperty
   a_lp_delay: assert property (p_lp_delay) else $error("low-power wake not held");

   property p_stab_len;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_STABLE && stab_cnt == STAB_LAST) |=> state == SRP_AWAKE && run_ok;
   endproperty
   a_stab_len: assert property (p_stab_len) else $error("stabilise end wrong");

   property p_unreg;
      @(posedge core_clk) disable iff (!rst_n)
      !REGULATED |-> !pm_eff && state != SRP_STABLE;
   endproperty
   a_unreg: assert property (p_unreg) else $error("unregulated mode used");

   property p_mode_write;
      @(posedge core_clk) disable iff (!rst_n)
      (access && apb_req.pwrite && hit_ctrl && REGULATED)
         |=> ctrl[`SRP_BIT_PM] == $past(apb_req.pwdata[1]);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode bit not stored");

   property p_normal_sleep;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_SLEEP && !pm_eff) |=> !reg_ctl.ldo_lowpower && !reg_ctl.ref_lowpower;
   endproperty
   a_normal_sleep: assert property (p_normal_sleep) else $error("normal sleep lowered");

   property p_ready_pulse;
      @(posedge core_clk) disable iff (!rst_n)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

   property p_ready_follows_setup;
      @(posedge core_clk) disable iff (!rst_n)
      (apb_req.psel && !apb_req.penable) |=> pready;
   endproperty
   a_ready_follows_setup: assert property (p_ready_follows_setup) else $error("no ready");

   property p_err_with_ready;
      @(posedge core_clk) disable iff (!rst_n)
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

   property p_unmapped_zero;
      @(posedge core_clk) disable iff (!rst_n)
      (pready && pslverr) |-> prdata == 32'h0000_0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped data not zero");

   property p_read_upper_zero;
      @(posedge core_clk) disable iff (!rst_n)
      pready |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

   property p_read_rsvd;
      @(posedge core_clk) disable iff (!rst_n)
      (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl)
         |=> prdata[`SRP_BIT_RSVD];
   endproperty
   a_read_rsvd: assert property (p_read_rsvd) else $error("reserved bit read low");

   property p_ref_tracks_ldo;
      @(posedge core_clk) disable iff (!rst_n)
      reg_ctl.ref_lowpower == reg_ctl.ldo_lowpower;
   endproperty
   a_ref_tracks_ldo: assert property (p_ref_tracks_ldo) else $error("ref and ldo differ");

   property p_awake_full_power;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_AWAKE) |-> !reg_ctl.ldo_lowpower && !reg_ctl.ref_lowpower;
   endproperty
   a_awake_full_power: assert property (p_awake_full_power) else $error("low power awake");

   property p_stable_full_power;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_STABLE) |-> !reg_ctl.ldo_lowpower && !reg_ctl.ref_lowpower;
   endproperty
   a_stable_full_power: assert property (p_stable_full_power) else $error("low power in wake");

   property p_lp_sleep;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_SLEEP && !wake_evt && pm_eff) |=> reg_ctl.ldo_lowpower;
   endproperty
   a_lp_sleep: assert property (p_lp_sleep) else $error("low power not applied");

   property p_hold_in_stable;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_STABLE && stab_cnt != STAB_LAST) |=> reg_ctl.wake_hold && !run_ok;
   endproperty
   a_hold_in_stable: assert property (p_hold_in_stable) else $error("hold dropped early");

   property p_hold_only_stable;
      @(posedge core_clk) disable iff (!rst_n)
      reg_ctl.wake_hold |-> state == SRP_STABLE;
   endproperty
   a_hold_only_stable: assert property (p_hold_only_stable) else $error("stray hold");

   property p_sleep_entry;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_AWAKE && sleep_req) |=> state == SRP_SLEEP && !run_ok;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

   property p_sleep_stays;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_SLEEP && !wake_evt) |=> state == SRP_SLEEP && !run_ok;
   endproperty
   a_sleep_stays: assert property (p_sleep_stays) else $error("left sleep unasked");

   property p_awake_run;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_AWAKE && !sleep_req) |=> run_ok;
   endproperty
   a_awake_run: assert property (p_awake_run) else $error("awake but halted");

   property p_cnt_bound;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_STABLE) |-> stab_cnt <= STAB_LAST;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("count past end");

   property p_cnt_step;
      @(posedge core_clk) disable iff (!rst_n)
      (state == SRP_STABLE && stab_cnt != STAB_LAST) |=> stab_cnt == $past(stab_cnt) + CW'(1);
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("count step wrong");

   property p_ctrl_hold;
      @(posedge core_clk) disable iff (!rst_n)
      !(access && apb_req.pwrite && hit_ctrl) |=> $stable(ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unasked");

   property p_unreg_ctrl;
      @(posedge core_clk) disable iff (!rst_n)
      !REGULATED |-> ctrl == `SRP_CTRL_RESET;
   endproperty
   a_unreg_ctrl: assert property (p_unreg_ctrl) else $error("unregulated control set");

   property p_state_legal;
      @(posedge core_clk) disable iff (!rst_n)
      state inside {SRP_AWAKE, SRP_SLEEP, SRP_STABLE};
   endproperty
   a_state_legal: assert property (p_state_legal) else $error("illegal state");

endmodule : srp_sleep_regulator

// ===== verif/testbench.sv
// Self-checking testbench for the sleep regulator power-mode block.
// Assumes srp_pkg is compiled first and srp_cfg.svh is on the include path.
`timescale 1ns/10ps
`include "srp_cfg.svh"
module testbench;
   import srp_pkg::*;
   localparam int unsigned STAB = 3;
   logic          core_clk;
   logic          rst_n;
   srp_apb_req_t  apb_req;
   logic          pready;
   logic [31:0]   prdata;
   logic          pslverr;
   logic          sleep_req;
   logic          wake_evt;
   srp_reg_ctl_t  reg_ctl;
   logic          run_ok;
   logic          run_ok_u;
   logic [31:0]   rd;
   logic          err;
   int            error_cnt;
   int            total_checks;

   srp_sleep_regulator #(.REGULATED(1'b1), .STAB_CYCLES(STAB)) srp_sleep_regulator_inst (
      .core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .sleep_req(sleep_req), .wake_evt(wake_evt),
      .reg_ctl(reg_ctl), .run_ok(run_ok));

   // Unregulated variant on the same stimulus; only its wake timing is watched
   srp_sleep_regulator #(.REGULATED(1'b0), .STAB_CYCLES(STAB)) srp_sleep_regulator_inst_u (
      .core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .pready(),
      .prdata(), .pslverr(), .sleep_req(sleep_req), .wake_evt(wake_evt),
      .reg_ctl(), .run_ok(run_ok_u));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask : apb

   // One sleep and wake; counts cycles that run_ok stays low after the wake
   task automatic nap(input logic [31:0] st, input int unsigned wait_n, input logic [2:0] lp);
      int unsigned n;
      n = 0;
      @(posedge core_clk);
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      chk(run_ok, 1'b0);
      chk(reg_ctl, lp);
      apb(1'b0, `SRP_ADDR_STATUS, 32'h0);
      chk(rd, st);
      @(posedge core_clk);
      wake_evt <= 1'b1;
      @(posedge core_clk);
      wake_evt <= 1'b0;
      @(posedge core_clk);
      chk(run_ok_u, 1'b1);
      if (wait_n != 0) chk(reg_ctl, 3'b001);
      while (run_ok !== 1'b1 && n < 20) begin
         n++;
         @(posedge core_clk);
      end
      chk(n, wait_n);
      chk(reg_ctl, 3'b000);
   endtask : nap

   task automatic summarize();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      repeat (4000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      apb_req = '0;
      sleep_req = 1'b0;
      wake_evt = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, `SRP_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b1, `SRP_ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, `SRP_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_0003);
      apb(1'b1, `SRP_ADDR_CTRL, 32'h1);
      apb(1'b0, `SRP_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'hFFC, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      chk(reg_ctl, 3'b000);
      nap(32'h1, 0, 3'b000);
      apb(1'b1, `SRP_ADDR_CTRL, 32'h3);
      nap(32'h5, STAB, 3'b110);
      apb(1'b1, `SRP_ADDR_CTRL, 32'h1);
      nap(32'h1, 0, 3'b000);
      summarize();
   end
endmodule : testbench
